// file: verilog/tpw_timer.sv
// Implementation choices: register access over APB and the register addresses.
`timescale 1ns/10ps
// 16-bit timer with compare, capture, single pulse and PWM
module tpw_timer
   import tpw_pkg::*;
#(
   parameter int ADDR_W = 8
) (
   // Clock and reset
   input  wire logic              clk_i,
   input  wire logic              srst_i,
   // APB slave
   input  wire logic              psel_i,
   input  wire logic              penable_i,
   input  wire logic              pwrite_i,
   input  wire logic [ADDR_W-1:0] paddr_i,
   input  wire logic [31:0]       pwdata_i,
   output logic [31:0]            prdata_o,
   output logic                   pready_o,
   output logic                   pslverr_o,
   // CPU side
   input  wire logic              cpu_imask_i,
   input  wire logic              halt_i,
   output logic                   timer_irq_o,
   // Pins
   input  wire logic              capture_pin_one_i,
   input  wire logic              capture_pin_two_i,
   input  wire logic              ext_clk_i,
   output logic                   first_compare_pin_o,
   output logic                   first_compare_oe_n_o,
   output logic                   second_compare_pin_o,
   output logic                   second_compare_oe_n_o
);
   import tpw_pkg::*;

   if (ADDR_W < 8) begin : g_bad_addr
      $error("tpw_timer: ADDR_W must be at least 8");
   end

   logic [7:0]  ctl1_reg, ctl2_reg;
   logic [15:0] cnt_reg, oc1_reg, oc2_reg, ic1_reg, ic2_reg;
   logic [4:0]  flags_reg, armed_reg, flag_set, flag_clr;
   logic        inh1_reg, inh2_reg, halt_d_reg, arm1_reg, arm2_reg;
   logic        pin1_reg, pin2_reg, oe1_n_reg, oe2_n_reg, irq_reg;
   logic [31:0] prdata_reg;
   logic        pready_reg, pslverr_reg;
   tpw_mode_t   mode_reg;
   logic        acc, wr, rd, ev1, ev2, ev_ext, tick, run, halt_exit;
   logic        m1, m2, opm_trig, cnt_wr, cap1_live;
   logic [7:0]  rd_mux;
   logic        rd_hit;

   // ---------------------------------------------------------------
   // Pin synchronisers and prescaler
   // ---------------------------------------------------------------
   tpw_edge u_cap1 (
      .clk_i   (clk_i),
      .srst_i  (srst_i),
      .pin_i   (capture_pin_one_i),
      .rise_i  (ctl1_reg[B_CAPTURE_ONE_EDGE_SELECT]),
      .pulse_o (ev1)
   );
   tpw_edge u_cap2 (
      .clk_i   (clk_i),
      .srst_i  (srst_i),
      .pin_i   (capture_pin_two_i),
      .rise_i  (ctl2_reg[B_IEDG2]),
      .pulse_o (ev2)
   );
   tpw_edge u_ext (
      .clk_i   (clk_i),
      .srst_i  (srst_i),
      .pin_i   (ext_clk_i),
      .rise_i  (ctl2_reg[B_EXEDG]),
      .pulse_o (ev_ext)
   );
   tpw_presc #(.PRE_W(3)) u_presc (
      .clk_i    (clk_i),
      .srst_i   (srst_i),
      .run_i    (run),
      .sel_i    (ctl2_reg[B_CCH:B_CCL]),
      .ext_ev_i (ev_ext),
      .tick_o   (tick)
   );

   // ---------------------------------------------------------------
   // Bus decode and event terms
   // ---------------------------------------------------------------
   // Access completes on the edge where pready is seen high
   assign acc       = psel_i & penable_i & pready_reg;
   assign wr        = acc & pwrite_i & rd_hit; // Unmapped writes are dropped
   assign rd        = acc & ~pwrite_i;
   // Wait mode needs nothing here; only halt stops the timer
   assign run       = ~halt_i;
   assign halt_exit = halt_d_reg & ~halt_i;
   // Either counter low byte write restarts the count
   assign cnt_wr    = wr & ((paddr_i[7:0] == A_CNTL) | (paddr_i[7:0] == A_ACNTL));
   // A pending high byte write holds the compare off
   assign m1        = tick & ~inh1_reg & (cnt_reg == oc1_reg);
   assign m2        = tick & ~inh2_reg & (cnt_reg == oc2_reg);
   assign opm_trig  = (mode_reg == TPW_M_OPM) & ev1 & run;
   // Capture pin one captures the count only in plain compare mode
   assign cap1_live = (mode_reg == TPW_M_CMP) & ev1 & run;

   // ---------------------------------------------------------------
   // Mode selection
   // ---------------------------------------------------------------
   // PWM bit outranks the single pulse bit
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         mode_reg <= TPW_M_CMP;
      end else if (ctl2_reg[B_PWM]) begin
         mode_reg <= TPW_M_PWM;
      end else if (ctl2_reg[B_OPM]) begin
         mode_reg <= TPW_M_OPM;
      end else begin
         mode_reg <= TPW_M_CMP;
      end
   end

   // ---------------------------------------------------------------
   // Control and compare registers
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         ctl1_reg <= CTL_RST;
         ctl2_reg <= CTL_RST;
      end else if (wr && paddr_i[7:0] == A_CTL1) begin
         ctl1_reg <= pwdata_i[7:0];
      end else if (wr && paddr_i[7:0] == A_CTL2) begin
         ctl2_reg <= pwdata_i[7:0];
      end
   end

   // High byte write arms the inhibit, low byte write releases it
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         oc1_reg  <= OCR_RST;
         oc2_reg  <= OCR_RST;
         inh1_reg <= 1'b0;
         inh2_reg <= 1'b0;
      end else if (wr) begin
         unique case (paddr_i[7:0])
            A_OC1H: begin
               oc1_reg[15:8] <= pwdata_i[7:0];
               inh1_reg      <= 1'b1;
            end
            A_OC1L: begin
               oc1_reg[7:0]  <= pwdata_i[7:0];
               inh1_reg      <= 1'b0;
            end
            A_OC2H: begin
               oc2_reg[15:8] <= pwdata_i[7:0];
               inh2_reg      <= 1'b1;
            end
            A_OC2L: begin
               oc2_reg[7:0]  <= pwdata_i[7:0];
               inh2_reg      <= 1'b0;
            end
            default: begin
               oc1_reg <= oc1_reg;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Free-running counter
   // ---------------------------------------------------------------
   // Held in halt; a reset wake restarts from the reset value
   always_ff @(posedge clk_i) begin
      if (srst_i || cnt_wr) begin
         cnt_reg <= CNT_RST;
      end else if (opm_trig) begin
         cnt_reg <= CNT_RST;
      end else if (mode_reg == TPW_M_PWM && m2) begin
         cnt_reg <= CNT_RST;
      end else if (tick) begin
         cnt_reg <= cnt_reg + 16'h0001;
      end
   end

   // ---------------------------------------------------------------
   // Capture registers and halt arming
   // ---------------------------------------------------------------
   // Capture two edges during halt, and capture one edges in compare mode, are remembered and replayed on exit
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         halt_d_reg <= 1'b0;
         arm1_reg   <= 1'b0;
         arm2_reg   <= 1'b0;
      end else begin
         halt_d_reg <= halt_i;
         arm1_reg   <= halt_i ? (arm1_reg | (ev1 & mode_reg == TPW_M_CMP)) : 1'b0;
         arm2_reg   <= halt_i ? (arm2_reg | ev2) : 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         ic1_reg <= 16'h0000;
         ic2_reg <= 16'h0000;
      end else begin
         if (opm_trig) begin
            ic1_reg <= OPM_CAP;
         end else if (cap1_live || (halt_exit && arm1_reg)) begin
            ic1_reg <= cnt_reg;
         end
         if ((ev2 && run) || (halt_exit && arm2_reg)) begin
            ic2_reg <= cnt_reg;
         end
      end
   end

   // ---------------------------------------------------------------
   // Status flags with two-step clear
   // ---------------------------------------------------------------
   // Compare flags stay quiet in PWM; period match reports as capture one
   always_comb begin
      flag_set         = '0;
      flag_set[F_CAPTURE_ONE_FLAG] = cap1_live | opm_trig | (halt_exit & arm1_reg)
                         | (mode_reg == TPW_M_PWM & m2);
      flag_set[F_MATCH_ONE_FLAG] = (mode_reg == TPW_M_CMP) & m1;
      flag_set[F_MATCH_TWO_FLAG] = (mode_reg != TPW_M_PWM) & m2;
      flag_set[F_TOF]  = tick & (cnt_reg == CNT_TOP);
      flag_set[F_CAPTURE_TWO_FLAG] = (ev2 & run) | (halt_exit & arm2_reg);
      flag_clr         = '0;
      if (acc) begin
         flag_clr[F_CAPTURE_ONE_FLAG] = armed_reg[F_CAPTURE_ONE_FLAG] & (paddr_i[7:0] == A_IC1L);
         flag_clr[F_MATCH_ONE_FLAG] = armed_reg[F_MATCH_ONE_FLAG] & (paddr_i[7:0] == A_OC1L);
         flag_clr[F_TOF]  = armed_reg[F_TOF]  & (paddr_i[7:0] == A_CNTL);
         flag_clr[F_CAPTURE_TWO_FLAG] = armed_reg[F_CAPTURE_TWO_FLAG] & (paddr_i[7:0] == A_IC2L);
         flag_clr[F_MATCH_TWO_FLAG] = armed_reg[F_MATCH_TWO_FLAG] & (paddr_i[7:0] == A_OC2L);
      end
   end

   // A new event in the clearing cycle survives
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         flags_reg <= '0;
         armed_reg <= '0;
      end else begin
         flags_reg <= (flags_reg & ~flag_clr) | flag_set;
         if (rd && paddr_i[7:0] == A_FLAGS) begin
            armed_reg <= (armed_reg & ~flag_clr) | prdata_reg[7:3];
         end else begin
            armed_reg <= armed_reg & ~flag_clr;
         end
      end
   end

   // ---------------------------------------------------------------
   // Compare pins
   // ---------------------------------------------------------------
   // Latches are low from reset; force bits act only in compare mode
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         pin1_reg <= 1'b0;
         pin2_reg <= 1'b0;
      end else begin
         unique case (mode_reg)
            TPW_M_PWM: begin
               if (m2) begin
                  pin1_reg <= ctl1_reg[B_SECOND_OUTPUT_LEVEL];
               end else if (m1) begin
                  pin1_reg <= ctl1_reg[B_FIRST_OUTPUT_LEVEL];
               end
            end
            TPW_M_OPM: begin
               if (opm_trig) begin
                  pin1_reg <= ctl1_reg[B_SECOND_OUTPUT_LEVEL];
               end else if (m1) begin
                  pin1_reg <= ctl1_reg[B_FIRST_OUTPUT_LEVEL];
               end
            end
            TPW_M_CMP: begin
               if (m1 || ctl1_reg[B_FORCE_LEVEL_ONE]) begin
                  pin1_reg <= ctl1_reg[B_FIRST_OUTPUT_LEVEL];
               end
               if (m2 || ctl1_reg[B_FORCE_LEVEL_TWO]) begin
                  pin2_reg <= ctl1_reg[B_SECOND_OUTPUT_LEVEL];
               end
            end
         endcase
      end
   end

   // Enable low means the timer owns the pin
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         oe1_n_reg <= 1'b1;
         oe2_n_reg <= 1'b1;
      end else begin
         oe1_n_reg <= ~ctl2_reg[B_FIRST_PIN_ENABLE];
         oe2_n_reg <= ~ctl2_reg[B_SECOND_PIN_ENABLE];
      end
   end

   // ---------------------------------------------------------------
   // Shared interrupt request
   // ---------------------------------------------------------------
   // Halt has no wake path here: the CPU clock is stopped anyway
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         irq_reg <= 1'b0;
      end else begin
         irq_reg <= ~cpu_imask_i & ~halt_i & (
            (ctl1_reg[B_CAPTURE_IRQ_ENABLE] & (flags_reg[F_CAPTURE_ONE_FLAG] | flags_reg[F_CAPTURE_TWO_FLAG])) |
            (ctl1_reg[B_MATCH_IRQ_ENABLE] & (flags_reg[F_MATCH_ONE_FLAG] | flags_reg[F_MATCH_TWO_FLAG])) |
            (ctl1_reg[B_ROLLOVER_IRQ_ENABLE] & flags_reg[F_TOF]));
      end
   end

   // ---------------------------------------------------------------
   // APB read data and response
   // ---------------------------------------------------------------
   always_comb begin
      rd_hit = 1'b1;
      unique case (paddr_i[7:0])
         A_CTL1:  rd_mux = ctl1_reg;
         A_CTL2:  rd_mux = ctl2_reg;
         A_FLAGS: rd_mux = {flags_reg, 3'h0};
         A_IC1H:  rd_mux = ic1_reg[15:8];
         A_IC1L:  rd_mux = ic1_reg[7:0];
         A_OC1H:  rd_mux = oc1_reg[15:8];
         A_OC1L:  rd_mux = oc1_reg[7:0];
         A_OC2H:  rd_mux = oc2_reg[15:8];
         A_OC2L:  rd_mux = oc2_reg[7:0];
         A_CNTH:  rd_mux = cnt_reg[15:8];
         A_CNTL:  rd_mux = cnt_reg[7:0];
         A_ACNTH: rd_mux = cnt_reg[15:8];
         A_ACNTL: rd_mux = cnt_reg[7:0];
         A_IC2H:  rd_mux = ic2_reg[15:8];
         A_IC2L:  rd_mux = ic2_reg[7:0];
         default: begin
            rd_mux = 8'h00;
            rd_hit = 1'b0;
         end
      endcase
      if (paddr_i > ADDR_W'(A_IC2L)) begin
         rd_hit = 1'b0;
      end
   end

   // Data sampled in setup; one wait-free access phase follows
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         prdata_reg  <= 32'h0000_0000;
         pready_reg  <= 1'b0;
         pslverr_reg <= 1'b0;
      end else begin
         pready_reg  <= psel_i & ~penable_i;
         pslverr_reg <= psel_i & ~penable_i & ~rd_hit;
         if (psel_i && !penable_i) begin
            prdata_reg <= pwrite_i ? 32'h0000_0000 : {24'h000000, rd_mux};
         end
      end
   end

   assign prdata_o              = prdata_reg;
   assign pready_o              = pready_reg;
   assign pslverr_o             = pslverr_reg;
   assign timer_irq_o           = irq_reg;
   assign first_compare_pin_o   = pin1_reg;
   assign second_compare_pin_o  = pin2_reg;
   assign first_compare_oe_n_o  = oe1_n_reg;
   assign second_compare_oe_n_o = oe2_n_reg;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   a_pwm_reload: assert property (@(posedge clk_i) disable iff (srst_i)
      (mode_reg == TPW_M_PWM && m2 && !cnt_wr) |=> cnt_reg == CNT_RST)
      else $error("PWM period match did not reload counter");
   a_pwm_pulse_lvl: assert property (@(posedge clk_i) disable iff (srst_i)
      (mode_reg == TPW_M_PWM && m1 && !m2) |=> pin1_reg == $past(ctl1_reg[B_FIRST_OUTPUT_LEVEL]))
      else $error("PWM pulse match level wrong");
   a_pwm_period_lvl: assert property (@(posedge clk_i) disable iff (srst_i)
      (mode_reg == TPW_M_PWM && m2) |=> pin1_reg == $past(ctl1_reg[B_SECOND_OUTPUT_LEVEL]))
      else $error("PWM period match level wrong");
   a_pwm_const_pin: assert property (@(posedge clk_i) disable iff (srst_i)
      (mode_reg == TPW_M_PWM && ctl1_reg[B_FIRST_OUTPUT_LEVEL] == ctl1_reg[B_SECOND_OUTPUT_LEVEL]
       && pin1_reg == ctl1_reg[B_FIRST_OUTPUT_LEVEL]) |=> $stable(pin1_reg))
      else $error("PWM pin toggled with equal levels");
   a_high_inhibit: assert property (@(posedge clk_i) disable iff (srst_i)
      (wr && paddr_i[7:0] == A_OC1H) |=> !m1 && !flag_set[F_MATCH_ONE_FLAG])
      else $error("Compare active after high byte write");
   a_pwm_no_ocf: assert property (@(posedge clk_i) disable iff (srst_i)
      (mode_reg == TPW_M_PWM && !flags_reg[F_MATCH_ONE_FLAG]) |=> !flags_reg[F_MATCH_ONE_FLAG])
      else $error("Compare flag set in PWM mode");
   a_pwm_capture_one_flag: assert property (@(posedge clk_i) disable iff (srst_i)
      (mode_reg == TPW_M_PWM && m2) |=> flags_reg[F_CAPTURE_ONE_FLAG])
      else $error("PWM period match missed capture one flag");
   a_halt_hold: assert property (@(posedge clk_i) disable iff (srst_i)
      (halt_i && !cnt_wr) |=> cnt_reg == $past(cnt_reg))
      else $error("Counter moved during halt");
   a_irq_masked: assert property (@(posedge clk_i) disable iff (srst_i)
      (cpu_imask_i || halt_i) |=> !irq_reg)
      else $error("Interrupt raised while masked");
   a_ovf_irq: assert property (@(posedge clk_i) disable iff (srst_i)
      (ctl1_reg[B_ROLLOVER_IRQ_ENABLE] && flags_reg[F_TOF] && !cpu_imask_i && !halt_i) |=> irq_reg)
      else $error("Rollover interrupt not raised");
endmodule // tpw_timer

// file: pkg/tpw_pkg.sv
package tpw_pkg;
   // ---------------------------------------------------------------
   // Register byte addresses
   // ---------------------------------------------------------------
   localparam logic [7:0] A_CTL1  = 8'h00;
   localparam logic [7:0] A_CTL2  = 8'h04;
   localparam logic [7:0] A_FLAGS = 8'h08;
   localparam logic [7:0] A_IC1H  = 8'h0C;
   localparam logic [7:0] A_IC1L  = 8'h10;
   localparam logic [7:0] A_OC1H  = 8'h14;
   localparam logic [7:0] A_OC1L  = 8'h18;
   localparam logic [7:0] A_OC2H  = 8'h1C;
   localparam logic [7:0] A_OC2L  = 8'h20;
   localparam logic [7:0] A_CNTH  = 8'h24;
   localparam logic [7:0] A_CNTL  = 8'h28;
   localparam logic [7:0] A_ACNTH = 8'h2C;
   localparam logic [7:0] A_ACNTL = 8'h30;
   localparam logic [7:0] A_IC2H  = 8'h34;
   localparam logic [7:0] A_IC2L  = 8'h38;
   // ---------------------------------------------------------------
   // Reset values, rollover count and single pulse capture value
   // ---------------------------------------------------------------
   localparam logic [7:0]  CTL_RST = 8'h00;
   localparam logic [15:0] CNT_RST = 16'hFFFC;
   localparam logic [15:0] CNT_TOP = 16'hFFFF;
   localparam logic [15:0] OCR_RST = 16'h8000;
   localparam logic [15:0] OPM_CAP = 16'hFFFD;
   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int B_CAPTURE_IRQ_ENABLE = 7, B_MATCH_IRQ_ENABLE = 6, B_ROLLOVER_IRQ_ENABLE = 5, B_FORCE_LEVEL_TWO = 4;
   localparam int B_FORCE_LEVEL_ONE = 3, B_SECOND_OUTPUT_LEVEL = 2, B_CAPTURE_ONE_EDGE_SELECT = 1, B_FIRST_OUTPUT_LEVEL = 0;
   localparam int B_FIRST_PIN_ENABLE = 7, B_SECOND_PIN_ENABLE = 6, B_OPM = 5, B_PWM = 4;
   localparam int B_CCH = 3, B_CCL = 2, B_IEDG2 = 1, B_EXEDG = 0;
   // Flag vector order, same as status bits 7..3
   localparam int F_CAPTURE_ONE_FLAG = 4, F_MATCH_ONE_FLAG = 3, F_TOF = 2, F_CAPTURE_TWO_FLAG = 1, F_MATCH_TWO_FLAG = 0;
   // ---------------------------------------------------------------
   // Clock select codes and prescale counts
   // ---------------------------------------------------------------
   localparam logic [1:0] CC_DIV4 = 2'h0;
   localparam logic [1:0] CC_DIV2 = 2'h1;
   localparam logic [1:0] CC_DIV8 = 2'h2;
   localparam logic [1:0] CC_EXT  = 2'h3;
   localparam logic [2:0] DIV2_LAST = 3'h1;
   localparam logic [2:0] DIV4_LAST = 3'h3;
   localparam logic [2:0] DIV8_LAST = 3'h7;
   // Operating modes
   typedef enum logic [2:0] {
      TPW_M_CMP = 3'b001,
      TPW_M_OPM = 3'b010,
      TPW_M_PWM = 3'b100
   } tpw_mode_t;
endpackage

// file: verilog/tpw_edge.sv
`timescale 1ns/10ps
// Two-flop synchroniser with selectable edge detection
module tpw_edge (
   // Clock and reset
   input  wire logic clk_i,
   input  wire logic srst_i,
   // Pin and edge choice (1 = rising)
   input  wire logic pin_i,
   input  wire logic rise_i,
   // One-cycle event
   output logic      pulse_o
);
   logic s1_reg, s2_reg, s3_reg;

   // First flop feeds only the second one
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         s1_reg <= 1'b0;
         s2_reg <= 1'b0;
         s3_reg <= 1'b0;
      end else begin
         s1_reg <= pin_i;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end

   // Edge seen on synchronised copies only
   assign pulse_o = rise_i ? (s2_reg & ~s3_reg) : (~s2_reg & s3_reg);
endmodule // tpw_edge

// file: verilog/tpw_presc.sv
`timescale 1ns/10ps
// Counter clock prescaler
module tpw_presc
   import tpw_pkg::*;
#(
   parameter int PRE_W = 3
) (
   // Clock and reset
   input  wire logic       clk_i,
   input  wire logic       srst_i,
   // Control
   input  wire logic       run_i,
   input  wire logic [1:0] sel_i,
   input  wire logic       ext_ev_i,
   // Counter advance strobe
   output logic            tick_o
);
   logic [PRE_W-1:0] div_reg;
   logic [PRE_W-1:0] last;

   // Terminal counts are three bits wide, so no other width is served
   if (PRE_W != 3) begin : g_bad_width
      $error("tpw_presc: PRE_W must be 3");
   end

   // Terminal count per clock code
   always_comb begin
      unique case (sel_i)
         CC_DIV2: last = DIV2_LAST;
         CC_DIV8: last = DIV8_LAST;
         default: last = DIV4_LAST;
      endcase
   end

   // Halt freezes the divider too
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         div_reg <= '0;
      end else if (run_i) begin
         div_reg <= (div_reg >= last) ? '0 : div_reg + 1'b1;
      end
   end

   assign tick_o = run_i & ((sel_i == CC_EXT) ? ext_ev_i : (div_reg >= last));
endmodule // tpw_presc

// file: tb/tpw_pins.sv
`timescale 1ns/10ps
// Far side pins: capture inputs and external counter clock
module tpw_pins (
   // Clock and controls from the bench
   input  wire logic clk_i,
   input  wire logic ext_run_i,
   input  wire logic cap_i,
   // Pins toward the timer
   output logic      ext_clk_o,
   output logic      cap_one_o,
   output logic      cap_two_o
);
   logic [1:0] div_reg = 2'h0;
   // Four-cycle clock, held still outside runs
   always_ff @(posedge clk_i) begin
      div_reg   <= ext_run_i ? div_reg + 2'h1 : 2'h0;
      ext_clk_o <= div_reg[1];
   end
   // Both capture pins move together
   assign cap_one_o = cap_i;
   assign cap_two_o = cap_i;
endmodule // tpw_pins

// file: tb/timer_pwm_mode_and_control_bench.sv
`timescale 1ns/10ps
module timer_pwm_mode_and_control_bench;
   import tpw_pkg::*;
   logic        clk_i = 0, srst_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0;
   logic [7:0]  paddr_i = 8'h00, v0, v1;
   logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
   logic        pready_o, pslverr_o, cpu_imask_i = 0, halt_i = 0, timer_irq_o, err;
   logic        cap1, cap2, ext_clk, pin1, oe1_n, pin2, oe2_n, ext_run = 0, cap = 0;
   int          n_errors = 0, n_checks = 0, seed = 17417, q, hi, t;
   int          dv[4] = '{4, 2, 8, 4};
   // ---------------------------------------------------------------
   // Clock, design and far side
   // ---------------------------------------------------------------
   initial forever #25 clk_i = ~clk_i;
   tpw_timer dut (.clk_i(clk_i), .srst_i(srst_i), .psel_i(psel_i), .penable_i(penable_i),
      .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
      .pready_o(pready_o), .pslverr_o(pslverr_o), .cpu_imask_i(cpu_imask_i),
      .halt_i(halt_i), .timer_irq_o(timer_irq_o), .capture_pin_one_i(cap1),
      .capture_pin_two_i(cap2), .ext_clk_i(ext_clk), .first_compare_pin_o(pin1),
      .first_compare_oe_n_o(oe1_n), .second_compare_pin_o(pin2),
      .second_compare_oe_n_o(oe2_n));
   tpw_pins far (.clk_i(clk_i), .ext_run_i(ext_run), .cap_i(cap), .ext_clk_o(ext_clk),
      .cap_one_o(cap1), .cap_two_o(cap2));
   // ---------------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------------
   task automatic summarize;
      $display("checks %0d mismatches %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_checks++;
      if (g !== e) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   // One APB transfer; waits for pready under a bound
   task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
      int n;
      @(posedge clk_i);
      psel_i <= 1; penable_i <= 0; pwrite_i <= w; paddr_i <= a; pwdata_i <= {24'h0, d};
      @(posedge clk_i);
      penable_i <= 1;
      n = 0;
      do begin @(posedge clk_i); n++; end while (pready_o !== 1'b1 && n < 20);
      if (n >= 20) begin chk("pready", 16'h1, 16'h0); summarize(); end
      rd = prdata_o; err = pslverr_o;
      psel_i <= 0; penable_i <= 0;
   endtask
   // Length of one high pulse on the first compare pin
   task automatic pulse;
      hi = 0; t = 0;
      while (pin1 !== 1'b0 && t < 400) begin @(posedge clk_i); t++; end
      while (pin1 !== 1'b1 && t < 400) begin @(posedge clk_i); t++; end
      while (pin1 === 1'b1 && t < 400) begin @(posedge clk_i); t++; hi++; end
      if (t >= 400) begin chk("pulse wait", 16'h1, 16'h0); summarize(); end
   endtask
   task automatic quiet(input logic lv);
      t = 0;
      repeat (150) begin @(posedge clk_i); t += (pin1 !== lv); end
   endtask
   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      repeat (3) @(posedge clk_i);
      srst_i <= 1'b0;
      apb(0, A_CTL1, 0); chk("control one reset", 16'h00, rd[15:0]);
      apb(0, 8'h3C, 0); chk("unmapped error", 16'h1, {15'h0, err});
      $display("reset test done");
      // Counting rate per clock code, including the external clock
      foreach (dv[k]) begin
         // External clock starts early so its sync delay falls outside the window
         ext_run <= (k == 3);
         apb(1, A_CTL2, 8'(k * 4 + 1));
         apb(0, A_CNTL, 0); v0 = rd[7:0];
         repeat (45) @(posedge clk_i);
         apb(0, A_CNTL, 0); v1 = rd[7:0] - v0;
         chk("count step", 16'(48 / dv[k]), {8'h0, v1});
      end
      ext_run <= 0;
      $display("prescale test done");
      // Period 20h, random pulse point, high after pulse match
      q = 1 + ($unsigned($random(seed)) % 31);
      apb(1, A_OC2H, 0); apb(1, A_OC2L, 8'h20); apb(1, A_OC1H, 0); apb(1, A_OC1L, q[7:0]);
      apb(1, A_CNTL, 0); // Restart from the reload value so the first period is short
      apb(1, A_CTL1, 8'h81);
      foreach (dv[k]) if (k < 2) begin
         apb(1, A_CTL2, k ? 8'hB6 : 8'h96);
         pulse(); pulse();
         chk("pulse length", 16'(2 * (32 - q)), 16'(hi));
      end
      apb(1, A_OC1H, 0); quiet(1'b0);
      chk("inhibited pulse", 16'h0, 16'(t));
      apb(1, A_OC1L, q[7:0]); pulse();
      chk("pulse after low byte", 16'(2 * (32 - q)), 16'(hi));
      $display("pwm test done");
      chk("pwm pin enables", 16'h1, {14'h0, oe1_n, oe2_n});
      apb(0, A_FLAGS, 0);
      chk("flags", 16'hA0, rd[15:0] & 16'hF8);
      chk("irq", 16'h1, {15'h0, timer_irq_o});
      cpu_imask_i <= 1; repeat (3) @(posedge clk_i);
      chk("masked irq", 16'h0, {15'h0, timer_irq_o});
      cpu_imask_i <= 0; cap <= 1; repeat (10) @(posedge clk_i);
      apb(0, A_FLAGS, 0); chk("capture two flag", 16'h1, {15'h0, rd[4]});
      $display("flag test done");
      apb(1, A_CTL1, 8'h85); quiet(1'b1); quiet(1'b1);
      chk("steady pin", 16'h0, 16'(t));
      halt_i <= 1; repeat (3) @(posedge clk_i);
      apb(0, A_CNTL, 0); v0 = rd[7:0];
      // A capture two edge while halted is held back until the wake
      cap <= 0; repeat (8) @(posedge clk_i);
      cap <= 1; repeat (12) @(posedge clk_i);
      apb(0, A_CNTL, 0); chk("halted count", {8'h0, v0}, rd[15:0]);
      chk("irq in halt", 16'h0, {15'h0, timer_irq_o});
      halt_i <= 0; repeat (3) @(posedge clk_i);
      apb(0, A_IC2L, 0); chk("capture at wake", {8'h0, v0}, rd[15:0]);
      $display("halt test done");
      // Plain compare: force bit drives pin two, then the two-step flag clear
      apb(1, A_CTL2, 8'h40); apb(1, A_CTL1, 8'h14); repeat (2) @(posedge clk_i);
      chk("forced pin two", 16'h1, {15'h0, pin2});
      chk("pin enables", 16'h2, {14'h0, oe1_n, oe2_n});
      apb(0, A_FLAGS, 0); chk("capture one flag", 16'h1, {15'h0, rd[7]});
      apb(0, A_IC1L, 0); chk("capture one unused", 16'h0, rd[15:0]);
      apb(0, A_FLAGS, 0); chk("capture one cleared", 16'h0, {15'h0, rd[7]});
      $display("compare test done");
      summarize();
   end
endmodule // timer_pwm_mode_and_control_bench
